// [vls_pkg.sv]
package vls_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_VOICE_TX = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_VOICE_RX = 4'h3;
    localparam logic [3:0] REG_ID = 4'h4;
    localparam logic [3:0] REG_CTL0 = 4'h8;

    // Control register fields
    localparam int CTRL_RUN = 0;
    localparam int CTRL_OFF_HOOK = 1;
    localparam int CTRL_START = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Status register fields
    localparam int STAT_RING = 0;
    localparam int STAT_LINE_CUR = 1;
    localparam int STAT_ID_VALID = 2;
    localparam int STAT_CTL_BUSY = 3;
    localparam int STAT_VOICE_NEW = 4;
    localparam int STAT_ONE_WIRE = 5;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam logic [2:0] SLOT_VOICE = 3'h0;
    localparam logic [2:0] SLOT_DATA = 3'h1;
    localparam logic [2:0] SLOT_CTRL = 3'h2;
    localparam logic [2:0] SLOT_SIG = 3'h3;
    localparam logic [2:0] FRAME_BYTES = 3'h4;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Signaling byte bit positions
    localparam int SIG_HOOK = 0;
    localparam int SIG_RING = 1;
    localparam int SIG_LINE_CUR = 2;

    // Control byte sequence and fill bytes
    localparam logic [2:0] CTL_LEN = 3'h6;
    localparam logic [7:0] CTL_IDLE = 8'hff;
    localparam logic [7:0] DATA_FILL = 8'h00;
    localparam logic [7:0] TX_IDLE = 8'hff;

endpackage : vls_pkg

// [vls_voice_line_slave.sv]
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module vls_voice_line_slave
    import vls_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic link_clock,
    input wire logic link_direction,
    input wire logic module_receive_line,
    input wire logic module_send_line_i,
    output logic module_send_line_o,
    output logic module_send_line_oe,
    input wire logic one_wire_n,
    output logic interface_reset_n,
    output logic module_installed_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic clk_s1;
        logic clk_s2;
        logic clk_s3;
        logic dir_s1;
        logic dir_s2;
        logic dir_s3;
        logic rxd_s1;
        logic rxd_s2;
        logic txi_s1;
        logic txi_s2;
        logic onew_s1;
        logic onew_s2;
        logic [2:0] bit_cnt;
        logic [2:0] byte_idx;
        logic [7:0] sh_tx;
        logic [7:0] sh_rx;
        logic run;
        logic off_hook;
        logic ctl_busy;
        logic [2:0] ctl_idx;
        logic [5:0][6:0] ctl_mem;
        logic [7:0] voice_tx;
        logic [7:0] voice_rx;
        logic voice_new;
        logic ring;
        logic line_cur;
        logic [7:0] id_byte;
        logic id_valid;
        logic id_pend;
        logic id_ph;
        logic sd_o;
        logic sd_oe;
        logic installed_n;
        logic [7:0] rd_data;
    } vls_state_t;

    vls_state_t s;
    vls_state_t n;

    logic lk_rise;
    logic lk_fall;
    logic dir_on;
    logic dir_off;
    logic load;
    logic [2:0] sel_idx;
    logic [2:0] rslot;
    logic [3:0] ctl_off;
    logic [7:0] tx_byte;
    logic [7:0] ctl_byte;
    logic [7:0] sig_out;
    logic [7:0] rx_byte;
    logic rx_bit;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        load = 1'b0;
        sel_idx = 3'h0;
        rslot = 3'h0;
        ctl_off = reg_addr - REG_CTL0;
        tx_byte = TX_IDLE;
        rx_bit = 1'b0;
        rx_byte = 8'h00;

        n.clk_s1 = link_clock;
        n.clk_s2 = s.clk_s1;
        n.clk_s3 = s.clk_s2;
        n.dir_s1 = link_direction;
        n.dir_s2 = s.dir_s1;
        n.dir_s3 = s.dir_s2;
        n.rxd_s1 = module_receive_line;
        n.rxd_s2 = s.rxd_s1;
        n.txi_s1 = module_send_line_i;
        n.txi_s2 = s.txi_s1;
        n.onew_s1 = one_wire_n;
        n.onew_s2 = s.onew_s1;

        lk_rise = s.clk_s2 & ~s.clk_s3;
        lk_fall = ~s.clk_s2 & s.clk_s3;
        dir_on = s.dir_s2 & ~s.dir_s3;
        dir_off = ~s.dir_s2 & s.dir_s3;

        n.installed_n = 1'b0;

        // --------------------------------------------------------
        // Register writes
        // --------------------------------------------------------
        if (reg_wr) begin
            case (reg_addr)
                REG_CTRL: begin
                    n.run = reg_wdata[CTRL_RUN];
                    // Unit reset forgets its identity; it resends later
                    if (!reg_wdata[CTRL_RUN]) begin
                        n.id_valid = 1'b0;
                        n.id_pend = 1'b0;
                    end
                    n.off_hook = reg_wdata[CTRL_OFF_HOOK];
                    // Start refused while a sequence runs
                    if (reg_wdata[CTRL_START] && !s.ctl_busy) begin
                        n.ctl_busy = 1'b1;
                        n.ctl_idx = 3'h0;
                    end
                end
                REG_VOICE_TX: begin
                    n.voice_tx = reg_wdata;
                end
                default: begin
                    if (reg_addr >= REG_CTL0 && ctl_off < {1'b0, CTL_LEN}) begin
                        n.ctl_mem[ctl_off[2:0]] = reg_wdata[6:0];
                    end
                end
            endcase
        end

        // Reading the received sample clears its flag; a new one wins
        if (reg_rd && reg_addr == REG_VOICE_RX) begin
            n.voice_new = 1'b0;
        end

        // --------------------------------------------------------
        // Outgoing byte selection
        // --------------------------------------------------------
        // Framing bit, write enable and data
        ctl_byte = s.ctl_busy ? {s.ctl_idx != 3'h0, s.ctl_mem[s.ctl_idx]} : CTL_IDLE;
        sig_out = 8'h00;
        sig_out[SIG_HOOK] = ~s.off_hook;

        // --------------------------------------------------------
        // Send phase: change data after the master's falling edge
        // --------------------------------------------------------
        if (dir_on) begin
            n.bit_cnt = 3'h0;
            n.byte_idx = 3'h0;
            sel_idx = 3'h0;
            load = 1'b1;
        end else if (s.dir_s2 && lk_fall) begin
            if (s.bit_cnt == LAST_BIT) begin
                n.bit_cnt = 3'h0;
                if (s.byte_idx < FRAME_BYTES) begin
                    n.byte_idx = s.byte_idx + 3'h1;
                end
                sel_idx = n.byte_idx;
                load = 1'b1;
                if (s.byte_idx == 3'h0 && !s.id_valid && s.run) begin
                    n.id_pend = 1'b1;
                end
                if (s.byte_idx == SLOT_CTRL && s.ctl_busy) begin
                    if (s.ctl_idx == CTL_LEN - 3'h1) begin
                        n.ctl_busy = 1'b0;
                        n.ctl_idx = 3'h0;
                    end else begin
                        n.ctl_idx = s.ctl_idx + 3'h1;
                    end
                end
            end else begin
                n.bit_cnt = s.bit_cnt + 3'h1;
                n.sh_tx = {s.sh_tx[6:0], 1'b0};
            end
        end

        case (sel_idx)
            SLOT_VOICE: tx_byte = s.voice_tx;
            SLOT_DATA: tx_byte = DATA_FILL;
            SLOT_CTRL: tx_byte = ctl_byte;
            SLOT_SIG: tx_byte = sig_out;
            default: tx_byte = TX_IDLE;
        endcase
        if (load) begin
            n.sh_tx = tx_byte;
        end

        n.sd_oe = s.dir_s2;
        n.sd_o = s.dir_s2 ? n.sh_tx[7] : 1'b0;

        // --------------------------------------------------------
        // Receive phase: sample on the master's rising edge
        // --------------------------------------------------------
        // ID on receive line, rest on shared line if one-wire
        if (s.id_ph && s.byte_idx == 3'h0) begin
            rx_bit = s.rxd_s2;
        end else if (!s.onew_s2) begin
            rx_bit = s.txi_s2;
        end else begin
            rx_bit = s.rxd_s2;
        end
        rx_byte = {s.sh_rx[6:0], rx_bit};
        rslot = s.byte_idx - {2'b00, s.id_ph};

        if (dir_off) begin
            n.bit_cnt = 3'h0;
            n.byte_idx = 3'h0;
            n.id_ph = s.id_pend;
        end else if (!s.dir_s2 && lk_rise) begin
            n.sh_rx = rx_byte;
            if (s.bit_cnt == LAST_BIT) begin
                n.bit_cnt = 3'h0;
                if (s.byte_idx <= FRAME_BYTES) begin
                    n.byte_idx = s.byte_idx + 3'h1;
                end
                if (s.id_ph && s.byte_idx == 3'h0) begin
                    n.id_byte = rx_byte;
                    n.id_valid = 1'b1;
                    n.id_pend = 1'b0;
                end else begin
                    case (rslot)
                        SLOT_VOICE: begin
                            n.voice_rx = rx_byte;
                            n.voice_new = 1'b1;
                        end
                        SLOT_SIG: begin
                            n.ring = rx_byte[SIG_RING];
                            n.line_cur = rx_byte[SIG_LINE_CUR];
                        end
                        default: begin
                        end
                    endcase
                end
            end else begin
                n.bit_cnt = s.bit_cnt + 3'h1;
            end
        end

        // --------------------------------------------------------
        // Register reads: data valid for one cycle only
        // --------------------------------------------------------
        n.rd_data = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: begin
                    n.rd_data[CTRL_RUN] = s.run;
                    n.rd_data[CTRL_OFF_HOOK] = s.off_hook;
                    n.rd_data[CTRL_START] = s.ctl_busy;
                end
                REG_VOICE_TX: n.rd_data = s.voice_tx;
                REG_STATUS: begin
                    n.rd_data[STAT_RING] = s.ring;
                    n.rd_data[STAT_LINE_CUR] = s.line_cur;
                    n.rd_data[STAT_ID_VALID] = s.id_valid;
                    n.rd_data[STAT_CTL_BUSY] = s.ctl_busy;
                    n.rd_data[STAT_VOICE_NEW] = s.voice_new;
                    n.rd_data[STAT_ONE_WIRE] = ~s.onew_s2;
                end
                REG_VOICE_RX: n.rd_data = s.voice_rx;
                REG_ID: n.rd_data = s.id_byte;
                default: begin
                    if (reg_addr >= REG_CTL0 && ctl_off < {1'b0, CTL_LEN}) begin
                        n.rd_data = {1'b0, s.ctl_mem[ctl_off[2:0]]};
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Module reset releases nothing: run clears to zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign module_send_line_o = s.sd_o;
    assign module_send_line_oe = s.sd_oe;
    assign interface_reset_n = s.run;
    assign module_installed_n = s.installed_n;
    assign reg_rdata = s.rd_data;

endmodule : vls_voice_line_slave

// [vls_voice_line_slave_assertions.sv]
`timescale 1ns/1ps
module vls_checker
    import vls_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic link_clock,
    input wire logic link_direction,
    input wire logic module_receive_line,
    input wire logic module_send_line_i,
    input wire logic module_send_line_o,
    input wire logic module_send_line_oe,
    input wire logic one_wire_n,
    input wire logic interface_reset_n,
    input wire logic module_installed_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_dir_lo;
        (!link_direction)[*6];
    endsequence
    sequence s_dir_hi;
        link_direction[*6];
    endsequence
    // ------
    // Checks
    // ------
    send_off_a: assert property (s_dir_lo |-> !module_send_line_oe)
        else $error("send pin driven while unit sends");
    send_on_a: assert property (s_dir_hi |-> module_send_line_oe)
        else $error("send pin not driven in send phase");
    // A released pin must not keep showing stale data
    quiet_line_a: assert property (!module_send_line_oe |-> !module_send_line_o)
        else $error("send data while not driving");
    sync_lag_a: assert property ($rose(link_direction) |-> !module_send_line_oe ##1
        !module_send_line_oe) else $error("direction used before synchronising");
    bit_hold_a: assert property ($rose(link_clock) |=> $stable(module_send_line_o)[*3])
        else $error("send bit moved around link rise");
    run_write_a: assert property (reg_wr && reg_addr == REG_CTRL |=>
        interface_reset_n == $past(reg_wdata[CTRL_RUN])) else $error("run line not updated");
    run_read_a: assert property (reg_rd && reg_addr == REG_CTRL |=>
        reg_rdata[CTRL_RUN] == interface_reset_n) else $error("run readback differs");
    reset_hold_a: assert property (disable iff (1'b0) !resetn |->
        !interface_reset_n && !module_send_line_oe) else $error("unit not held in reset");
    installed_a: assert property (module_installed_n == 1'b0)
        else $error("installed indication missing");
    status_pad_a: assert property (reg_rd && reg_addr == REG_STATUS |=>
        reg_rdata[7:6] == 2'b00) else $error("status spare bits set");
endmodule : vls_checker

bind vls_voice_line_slave vls_checker chk_i (.clk(clk), .resetn(resetn),
    .link_clock(link_clock), .link_direction(link_direction),
    .module_receive_line(module_receive_line), .module_send_line_i(module_send_line_i),
    .module_send_line_o(module_send_line_o), .module_send_line_oe(module_send_line_oe),
    .one_wire_n(one_wire_n), .interface_reset_n(interface_reset_n),
    .module_installed_n(module_installed_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// [vls_line_model.sv]
`timescale 1ns/1ps
module vls_line_model (
    output logic link_clock,
    output logic link_direction,
    output logic unit_data,
    input wire logic module_send_line_o
);
    initial begin
        link_clock = 1'b0;
        link_direction = 1'b0;
        unit_data = 1'b1;
    end
    // ------
    // Frame
    // ------
    // send then receive
    task automatic frame(input logic [39:0] rx, input int n, output logic [31:0] got);
        #7 link_direction = 1'b1;
        #200;
        for (int i = 0; i < 32; i++) begin
            link_clock = 1'b1;
            #160 link_clock = 1'b0;
            got = {got[30:0], module_send_line_o};
            #160;
        end
        link_direction = 1'b0;
        #200;
        for (int i = 0; i < 8 * n; i++) begin
            unit_data = rx[8 * n - 1 - i];
            link_clock = 1'b1;
            #160 link_clock = 1'b0;
            #160;
        end
        // Released line shows the inverse, not a held value
        unit_data = ~unit_data;
        #200;
    endtask : frame
endmodule : vls_line_model

// [tb_voice_line_serial_slave.sv]
`timescale 1ns/1ps
module tb_voice_line_serial_slave;
    import vls_pkg::*;
    logic clk = 1'b0;
    logic resetn;
    logic one_wire_n = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic link_clock, link_direction, unit_data, send_o, send_oe;
    logic interface_reset_n, module_installed_n;
    logic [31:0] got;
    int n_errors = 0;
    int num_checks = 0;
    always #20 clk = ~clk;
    vls_line_model lu (.link_clock(link_clock), .link_direction(link_direction),
        .unit_data(unit_data), .module_send_line_o(send_o));
    vls_voice_line_slave dut (.clk(clk), .resetn(resetn), .link_clock(link_clock),
        .link_direction(link_direction), .module_receive_line(unit_data),
        .module_send_line_i(send_oe ? send_o : unit_data), .module_send_line_o(send_o),
        .module_send_line_oe(send_oe), .one_wire_n(one_wire_n),
        .interface_reset_n(interface_reset_n), .module_installed_n(module_installed_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    // ------
    // Helpers
    // ------
    task automatic results;
        if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        repeat (2) @(negedge clk);
    endtask : wr
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(what, reg_rdata, exp);
    endtask : rchk
    // ------
    // Scenarios
    // ------
    task automatic t_id_frame;
        chk("run line", interface_reset_n, 32'h0);
        chk("installed", module_installed_n, 32'h0);
        wr(REG_VOICE_TX, 8'ha5);
        wr(REG_CTRL, 8'h01);
        chk("run on", interface_reset_n, 32'h1);
        lu.frame(40'h3c5a817e06, 5, got);
        chk("voice out", got[31:24], 32'ha5);
        chk("data out", got[23:16], 32'h00);
        chk("ctl idle", got[15:8], 32'hff);
        chk("hook on", got[0], 32'h1);
        rchk(REG_STATUS, 8'h17, "status");
        rchk(REG_ID, 8'h3c, "id");
        rchk(REG_VOICE_RX, 8'h5a, "voice in");
        rchk(REG_STATUS, 8'h07, "status clr");
        // Undefined signaling bits set, ring and current clear
        lu.frame(40'hc30000f9, 4, got);
        rchk(REG_STATUS, 8'h14, "sig spare");
        rchk(REG_VOICE_RX, 8'hc3, "voice in2");
    endtask : t_id_frame
    task automatic t_ctl_seq;
        for (int i = 0; i < 6; i++) wr(REG_CTL0 + 4'(i), 8'h0a + 8'(i));
        wr(REG_CTRL, 8'h07);
        rchk(REG_CTRL, 8'h07, "ctl busy");
        // Seventh frame must fall back to the idle control byte
        for (int i = 0; i < 7; i++) begin
            lu.frame(40'h0, 4, got);
            chk("ctl byte", got[15:8], (i == 6) ? 32'hff : {i != 0, 7'h0a + 7'(i)});
            chk("hook off", got[0], 32'h0);
        end
        rchk(REG_CTRL, 8'h03, "ctl done");
    endtask : t_ctl_seq
    task automatic t_misc;
        wr(4'hf, 8'h55);
        rchk(4'hf, 8'h00, "unmapped");
        rchk(4'h6, 8'h00, "gap");
        @(posedge clk);
        one_wire_n <= 1'b0;
        lu.frame(40'h69000004, 4, got);
        rchk(REG_STATUS, 8'h36, "one wire");
        rchk(REG_VOICE_RX, 8'h69, "shared in");
        wr(REG_CTRL, 8'h00);
        chk("run off", interface_reset_n, 32'h0);
        rchk(REG_STATUS, 8'h22, "id drop");
    endtask : t_misc
    // Mid-run module reset must pull the unit into reset as well
    task automatic t_reset;
        wr(REG_CTRL, 8'h01);
        chk("run again", interface_reset_n, 32'h1);
        @(posedge clk);
        resetn <= 1'b0;
        @(negedge clk);
        chk("run in reset", interface_reset_n, 32'h0);
        chk("unit held", interface_reset_n, 32'h0);
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk("run after reset", interface_reset_n, 32'h0);
        rchk(REG_STATUS, 8'h20, "status reset");
    endtask : t_reset
    initial begin
        // Scheduled so the design sees a real falling edge on its reset
        resetn <= 1'b0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        t_id_frame();
        t_ctl_seq();
        t_misc();
        t_reset();
        results();
    end
    initial begin
        #1_000_000;
        n_errors++;
        results();
    end
endmodule : tb_voice_line_serial_slave
